// ===== mmsd_pkg.sv
// Purpose: constants for the memory map strobe decoder
// Assumes: 16-bit code and data address space, 8-bit data
// Notes:   ranges are inclusive, given as low and high addresses
package mmsd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  typedef enum logic [1:0] {
    MMSD_RAM_8K  = 2'b00,
    MMSD_RAM_4K  = 2'b01,
    MMSD_ROM_8K  = 2'b10,
    MMSD_ROM_32K = 2'b11
  } mmsd_variant_t;
  localparam logic [15:0] GP_RAM_LO   = 16'h0000;
  localparam logic [15:0] GP_RAM_HI   = 16'h1B3F;
  localparam logic [15:0] ALIAS_LO    = 16'h1B40;
  localparam logic [15:0] ALIAS_HI    = 16'h1F3F;
  localparam logic [15:0] BULK_LO     = 16'h7B40;
  localparam logic [15:0] BULK_HI     = 16'h7F3F;
  localparam logic [15:0] CTRL_LO     = 16'h7F40;
  localparam logic [15:0] CTRL_HI     = 16'h7FFF;
  localparam logic [15:0] ISO_LO      = 16'h2000;
  localparam logic [15:0] ISO_HI      = 16'h27FF;
  localparam logic [15:0] ROM8_CODE_HI  = 16'h1FFF;
  localparam logic [15:0] ROM8_DATA_HI  = 16'h07FF;
  localparam logic [15:0] ROM32_CODE_HI = 16'h7FFF;
  localparam logic [15:0] ROM32_DATA_HI = 16'h0FFF;
  localparam int unsigned BUF_BLK_BYTES = 64;
  localparam int unsigned BUF_COUNT     = 16;
  localparam logic [3:0]  BUF_BLK_SHIFT = 4'h6;
endpackage

// ===== mmsd_decoder.sv
// Purpose: qualify external fetch/read/write strobes by the internal map
// Assumes: core strobes active low, same-clock as this block
// Notes:   decode is combinational; only the code select pin is registered
`timescale 1ns/1ps
`default_nettype none
module mmsd_decoder #(
  parameter mmsd_pkg::mmsd_variant_t VARIANT = mmsd_pkg::MMSD_RAM_8K
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          external_code_select,
  input  wire logic                          iso_endpoint_disable,
  input  wire logic [mmsd_pkg::ADDR_W-1:0]   core_addr,
  input  wire logic [mmsd_pkg::DATA_W-1:0]   core_wdata,
  input  wire logic                          core_fetch_n,
  input  wire logic                          core_rd_n,
  input  wire logic                          core_wr_n,
  output logic [mmsd_pkg::ADDR_W-1:0]        ext_addr,
  output logic [mmsd_pkg::DATA_W-1:0]        ext_wdata,
  output logic                               ext_data_oe,
  output logic                               program_fetch_strobe_n,
  output logic                               ext_rd_n,
  output logic                               ext_wr_n,
  output logic                               ext_cs_n,
  output logic                               ext_oe_n,
  output logic                               int_code_sel,
  output logic                               int_data_sel,
  output logic                               int_gp_ram_sel,
  output logic                               int_bulk_sel,
  output logic                               int_ctrl_sel,
  output logic                               int_iso_ram_sel,
  output logic [3:0]                         alias_buf_index,
  output logic                               alias_buf_dir_in,
  output logic                               port_strobe_claim
);
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // code select pin passes two flops before use
  logic sel_meta_q;
  logic sel_sync_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      sel_meta_q <= external_code_select;
      sel_sync_q <= sel_meta_q;
    end
  end

  wire is_rom  = (VARIANT == mmsd_pkg::MMSD_ROM_8K) || (VARIANT == mmsd_pkg::MMSD_ROM_32K);
  wire is_ram8 = (VARIANT == mmsd_pkg::MMSD_RAM_8K);

  // region hits
  wire hit_gp    = in_rng(core_addr, mmsd_pkg::GP_RAM_LO, mmsd_pkg::GP_RAM_HI);
  wire hit_bulk  = in_rng(core_addr, mmsd_pkg::BULK_LO, mmsd_pkg::BULK_HI);
  wire hit_ctrl  = in_rng(core_addr, mmsd_pkg::CTRL_LO, mmsd_pkg::CTRL_HI);
  wire hit_alias = is_ram8 && in_rng(core_addr, mmsd_pkg::ALIAS_LO, mmsd_pkg::ALIAS_HI);
  wire hit_iso   = iso_endpoint_disable && in_rng(core_addr, mmsd_pkg::ISO_LO, mmsd_pkg::ISO_HI);
  wire hit_r8d   = in_rng(core_addr, mmsd_pkg::GP_RAM_LO, mmsd_pkg::ROM8_DATA_HI);
  wire hit_r32d  = in_rng(core_addr, mmsd_pkg::GP_RAM_LO, mmsd_pkg::ROM32_DATA_HI);
  wire hit_r8c   = in_rng(core_addr, mmsd_pkg::GP_RAM_LO, mmsd_pkg::ROM8_CODE_HI);
  wire hit_r32c  = in_rng(core_addr, mmsd_pkg::GP_RAM_LO, mmsd_pkg::ROM32_CODE_HI);

  // data RAM per variant
  wire hit_data_ram = (VARIANT == mmsd_pkg::MMSD_ROM_8K)  ? hit_r8d :
                      (VARIANT == mmsd_pkg::MMSD_ROM_32K) ? hit_r32d :
                      hit_gp;
  wire data_int = hit_data_ram || hit_bulk || hit_ctrl || hit_alias || hit_iso;

  // code internal per variant
  wire code_int = (VARIANT == mmsd_pkg::MMSD_ROM_8K)  ? hit_r8c :
                  (VARIANT == mmsd_pkg::MMSD_ROM_32K) ? hit_r32c :
                  (!sel_sync_q && hit_gp);

  wire fetch_act = !core_fetch_n;
  wire rd_act    = !core_rd_n;
  wire wr_act    = !core_wr_n;

  // qualified strobes, combinational within the bus cycle
  assign program_fetch_strobe_n = !(fetch_act && !code_int);
  assign ext_rd_n = !(rd_act && !data_int);
  assign ext_wr_n = !(wr_act && !data_int);
  assign ext_cs_n = ext_rd_n && ext_wr_n && program_fetch_strobe_n;
  assign ext_oe_n = ext_rd_n && program_fetch_strobe_n;

  // internal selects; RAM variants merge fetch and read in low RAM
  assign int_code_sel    = fetch_act && code_int;
  assign int_data_sel    = (rd_act || wr_act) && data_int;
  assign int_gp_ram_sel  = (fetch_act && code_int && !is_rom) || ((rd_act || wr_act) && hit_data_ram);
  assign int_bulk_sel    = (rd_act || wr_act) && (hit_bulk || hit_alias);
  assign int_ctrl_sel    = (rd_act || wr_act) && hit_ctrl;
  assign int_iso_ram_sel = (rd_act || wr_act) && hit_iso;

  // alias buffers: 64-byte blocks, endpoint 7 out lowest
  wire [15:0] alias_off = core_addr - mmsd_pkg::ALIAS_LO;
  wire [3:0]  blk       = alias_off[mmsd_pkg::BUF_BLK_SHIFT +: 4];
  assign alias_buf_index  = 4'hF - blk;
  assign alias_buf_dir_in = blk[0];

  // expansion bus: address and data outward only
  assign ext_addr          = core_addr;
  assign ext_wdata         = core_wdata;
  assign ext_data_oe       = !ext_wr_n;
  assign port_strobe_claim = !sel_sync_q ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== mmsd_decoder_props.sv
// Purpose: port checks for mmsd_decoder; Assumes: RAM_8K map; Notes: combinational outputs except port_strobe_claim
`timescale 1ns/1ps
`default_nettype none
module mmsd_decoder_props (
  input wire logic        clk, rstn, external_code_select, iso_endpoint_disable, core_rd_n, core_wr_n, core_fetch_n,
  input wire logic        ext_data_oe, program_fetch_strobe_n, ext_rd_n, ext_wr_n, ext_cs_n, ext_oe_n, port_strobe_claim,
  input wire logic [15:0] core_addr, ext_addr,
  input wire logic [3:0]  alias_buf_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic in_low   = core_addr <= 16'h1B3F;
  wire logic in_alias = core_addr >= 16'h1B40 && core_addr <= 16'h1F3F;
  wire logic in_mid   = core_addr >= 16'h2800 && core_addr < 16'h7B40;
  chk_cs_combine: assert property (ext_cs_n == (ext_rd_n & ext_wr_n & program_fetch_strobe_n)) else $error("cs");
  chk_oe_combine: assert property (ext_oe_n == (ext_rd_n & program_fetch_strobe_n)) else $error("oe");
  chk_low_fetch_gone: assert property (!port_strobe_claim && in_low |-> program_fetch_strobe_n) else $error("fetch");
  chk_low_quiet: assert property (in_low |-> ext_rd_n && ext_wr_n) else $error("low ram strobe");
  chk_regs_quiet: assert property (core_addr >= 16'h7B40 && core_addr <= 16'h7FFF |-> ext_rd_n && ext_wr_n)
    else $error("reg strobe");
  chk_iso_quiet: assert property (iso_endpoint_disable && core_addr[15:11] == 5'h04 |-> ext_rd_n && ext_wr_n)
    else $error("iso strobe");
  chk_mid_pass: assert property (in_mid |-> ext_rd_n == core_rd_n && ext_wr_n == core_wr_n) else $error("mid");
  chk_sync_delay: assert property ($rose(external_code_select) |=> !port_strobe_claim ##1 port_strobe_claim)
    else $error("sync delay");
  chk_fetch_ext: assert property (port_strobe_claim |-> program_fetch_strobe_n == core_fetch_n) else $error("ext");
  chk_alias_order: assert property (in_alias |-> alias_buf_index == 4'hF - 4'((core_addr - 16'h1B40) >> 6))
    else $error("alias index");
  chk_addr_pass: assert property (ext_addr == core_addr && ext_data_oe == !ext_wr_n) else $error("bus");
endmodule
bind mmsd_decoder mmsd_decoder_props chk_u (.*);
`default_nettype wire

// ===== mmsd_ext_mem.sv
// Purpose: external byte memory; Assumes: async read; Notes: idle bus shows inverse of last byte
`timescale 1ns/1ps
`default_nettype none
module mmsd_ext_mem (
  input  wire logic        clk, cs_n, oe_n, wr_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem_q [256];
  logic [7:0] last_q;
  always_ff @(posedge clk) begin
    if (!cs_n && !wr_n) mem_q[addr[7:0]] <= wdata;
    if (!cs_n && !oe_n) last_q <= mem_q[addr[7:0]];
  end
  assign rdata = (!cs_n && !oe_n) ? mem_q[addr[7:0]] : ~last_q;
endmodule
`default_nettype wire

// ===== tb_memory_map_strobe_decoder.sv
// Purpose: bench for mmsd_decoder; Assumes: RAM_8K; Notes: outputs sampled 1 ns after edge
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_strobe_decoder;
  logic clk = 1'b0, rstn = 1'b0, external_code_select = 1'b0, iso_endpoint_disable = 1'b0;
  logic core_fetch_n = 1'b1, core_rd_n = 1'b1, core_wr_n = 1'b1, ext_data_oe, program_fetch_strobe_n, ext_rd_n;
  logic ext_wr_n, ext_cs_n, ext_oe_n, int_code_sel, int_data_sel, int_gp_ram_sel, int_bulk_sel, int_ctrl_sel;
  logic int_iso_ram_sel, alias_buf_dir_in, port_strobe_claim;
  logic [15:0] core_addr = 16'h0000, ext_addr;
  logic [7:0]  core_wdata = 8'h00, ext_wdata, mem_rdata;
  logic [3:0]  alias_buf_index;
  int failures = 0, check_count = 0, cycles = 0;
  mmsd_decoder dut_u (.*);
  mmsd_ext_mem mem_u (.clk(clk), .cs_n(ext_cs_n), .oe_n(ext_oe_n), .wr_n(ext_wr_n), .addr(ext_addr),
                      .wdata(ext_wdata), .rdata(mem_rdata));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic [2:0] frw);
    @(posedge clk);
    core_addr <= a;
    {core_fetch_n, core_rd_n, core_wr_n} <= frw;
    core_wdata <= a[7:0] ^ 8'h5A;
    #1;
  endtask
  task automatic idle;
    @(posedge clk);
    {core_fetch_n, core_rd_n, core_wr_n} <= 3'h7;
  endtask
  task automatic t_ext_rw;
    acc(16'h3011, 3'h6);
    chk({ext_wr_n, ext_cs_n, ext_oe_n, ext_data_oe}, 8'h03);
    chk(ext_wdata, 8'h4B);
    idle();
    acc(16'h3011, 3'h5);
    chk({ext_rd_n, ext_cs_n, ext_oe_n}, 8'h00);
    chk(mem_rdata, 8'h4B);
    idle();
  endtask
  task automatic t_regions;
    logic [15:0] a [8] = '{16'h0000, 16'h1B3F, 16'h1B40, 16'h7B40, 16'h7FFF, 16'h1F40, 16'h2000, 16'h27FF};
    logic [7:0] ext = 8'h60;
    logic [3:0] sel [8] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h0, 4'h0, 4'h1};
    for (int i = 0; i < 8; i++) begin
      iso_endpoint_disable <= (i == 7);
      acc(a[i], 3'h5);
      chk({ext_rd_n, ext_cs_n}, ext[i] ? 8'h00 : 8'h03);
      chk({int_data_sel, int_gp_ram_sel, int_bulk_sel, int_ctrl_sel, int_iso_ram_sel}, {~ext[i], sel[i]});
      if (i == 2) chk({alias_buf_dir_in, alias_buf_index}, 8'h0F);
      idle();
      acc(a[i], 3'h6);
      chk(ext_wr_n, !ext[i]);
      idle();
    end
    iso_endpoint_disable <= 1'b0;
  endtask
  task automatic t_fetch;
    acc(16'h1B3F, 3'h3);
    chk({program_fetch_strobe_n, ext_cs_n}, 8'h03);
    chk({int_code_sel, int_gp_ram_sel}, 8'h03);
    idle();
    acc(16'h1B40, 3'h3);
    chk({program_fetch_strobe_n, ext_oe_n}, 8'h00);
    idle();
    external_code_select <= 1'b1;
    repeat (3) @(posedge clk);
    acc(16'h0000, 3'h3);
    chk({program_fetch_strobe_n, port_strobe_claim}, 8'h01);
    idle();
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_ext_rw();
    t_regions();
    t_fetch();
    summarize();
  end
endmodule
`default_nettype wire
